// ==== abac_pkg.sv ====
// package for the address block access control: descriptor layout and encodings
// assumes a single processor clock and a control-register move port from the core
package abac_pkg;
  localparam int ABAC_DW = 32;
  localparam int ABAC_BASE_HI = 31;
  localparam int ABAC_BASE_LO = 24;
  localparam int ABAC_MASK_HI = 23;
  localparam int ABAC_MASK_LO = 16;
  localparam int ABAC_EN_BIT = 15;
  localparam int ABAC_PRIV_HI = 14;
  localparam int ABAC_PRIV_LO = 13;
  localparam int ABAC_UHI_BIT = 9;
  localparam int ABAC_ULO_BIT = 8;
  localparam int ABAC_CP_HI = 6;
  localparam int ABAC_CP_LO = 5;
  localparam int ABAC_WP_BIT = 2;
  localparam logic [31:0] ABAC_WR_MASK = 32'hFFFFE364;
  localparam logic [31:0] ABAC_RESET_VAL = 32'h00000000;
  localparam int ABAC_PAGE_BITS = 12;
  localparam logic [1:0] ABAC_SEL_INSTR0 = 2'h0;
  localparam logic [1:0] ABAC_SEL_INSTR1 = 2'h1;
  localparam logic [1:0] ABAC_SEL_DATA0 = 2'h2;
  localparam logic [1:0] ABAC_SEL_DATA1 = 2'h3;
  localparam logic [1:0] ABAC_PRIV_USER = 2'h0;
  localparam logic [1:0] ABAC_PRIV_SUPER = 2'h1;
  typedef enum logic [1:0] {
    ABAC_CP_WT = 2'h0,
    ABAC_CP_CB = 2'h1,
    ABAC_CP_NCS = 2'h2,
    ABAC_CP_NC = 2'h3
  } abac_cache_policy_e;
endpackage

// ==== abac_chk_if.sv ====
// interface between the top and one access_checker unit
// assumes both ends run on mclk
interface abac_chk_if;
  import abac_pkg::*;
  logic [31:0] desc0;
  logic [31:0] desc1;
  logic [7:0] addr_hi;
  logic priv;
  logic hit;
  logic [1:0] policy;
  logic wprot;
  logic [1:0] uattr;
  modport top (output desc0, output desc1, output addr_hi, output priv,
               input hit, input policy, input wprot, input uattr);
  modport chk (input desc0, input desc1, input addr_hi, input priv,
               output hit, output policy, output wprot, output uattr);
endinterface

// ==== abac_access_checker.sv ====
// one access_checker unit: two descriptors matched against an address
// assumes descriptors and address are stable in mclk domain; purely combinational
module abac_access_checker
  import abac_pkg::*;
(
  abac_chk_if.chk c
);
  logic [1:0] m;
  logic [31:0] d [2];
  assign d[0] = c.desc0;
  assign d[1] = c.desc1;
  for (genvar i = 0; i < 2; i++) begin : g_match
    logic [7:0] base;
    logic [7:0] msk;
    logic [1:0] pf;
    logic pok;
    assign base = d[i][ABAC_BASE_HI:ABAC_BASE_LO];
    assign msk = d[i][ABAC_MASK_HI:ABAC_MASK_LO];
    assign pf = d[i][ABAC_PRIV_HI:ABAC_PRIV_LO];
    assign pok = (pf == ABAC_PRIV_USER) ? !c.priv :
                 (pf == ABAC_PRIV_SUPER) ? c.priv : 1'b1;
    // masked bits drop out; any mask pattern allowed
    assign m[i] = d[i][ABAC_EN_BIT] && pok && (((base ^ c.addr_hi) & ~msk) == 8'h00);
  end
  logic [31:0] sel;
  assign sel = m[0] ? d[0] : d[1];
  assign c.hit = |m;
  assign c.policy = c.hit ? sel[ABAC_CP_HI:ABAC_CP_LO] : 2'h0;
  assign c.wprot = c.hit && sel[ABAC_WP_BIT];
  assign c.uattr = c.hit ? {sel[ABAC_UHI_BIT], sel[ABAC_ULO_BIT]} : 2'h0;
endmodule

// ==== abac_top.sv ====
// top of the access control: descriptor registers and two access_checker units
// assumes core requests are synchronous to mclk and held one cycle each
module abac_top
  import abac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic ctl_wr,
  input wire logic ctl_rd,
  input wire logic ctl_super,
  input wire logic [1:0] ctl_sel,
  input wire logic [31:0] ctl_wdata,
  output logic [31:0] ctl_rdata,
  output logic ctl_ack,
  output logic ctl_priv_err,
  input wire logic if_req,
  input wire logic [31:0] if_addr,
  input wire logic if_priv,
  output logic if_valid,
  output logic [31:0] if_paddr,
  output logic [1:0] if_policy,
  output logic [1:0] if_uattr,
  output logic [19:0] if_page,
  input wire logic op_req,
  input wire logic [31:0] op_addr,
  input wire logic op_priv,
  input wire logic op_write,
  input wire logic op_rmw,
  output logic op_valid,
  output logic [31:0] op_paddr,
  output logic [1:0] op_policy,
  output logic [1:0] op_uattr,
  output logic [19:0] op_page,
  output logic op_access_err,
  input wire logic bus_start,
  input wire logic bus_is_data,
  output logic user_attr_pin_hi,
  output logic user_attr_pin_lo
);
  logic [31:0] desc_reg [4];
  logic [31:0] desc_next [4];
  logic [31:0] rdata_reg, rdata_next;
  logic ack_reg, ack_next, perr_reg, perr_next;
  logic if_valid_reg, if_valid_next, op_valid_reg, op_valid_next, err_reg, err_next;
  logic [31:0] if_paddr_reg, if_paddr_next, op_paddr_reg, op_paddr_next;
  logic [1:0] if_pol_reg, if_pol_next, op_pol_reg, op_pol_next;
  logic [1:0] if_ua_reg, if_ua_next, op_ua_reg, op_ua_next;
  logic [1:0] pin_reg, pin_next;

  abac_chk_if ich();
  abac_chk_if dch();
  assign ich.desc0 = desc_reg[ABAC_SEL_INSTR0];
  assign ich.desc1 = desc_reg[ABAC_SEL_INSTR1];
  assign ich.addr_hi = if_addr[ABAC_BASE_HI:ABAC_BASE_LO];
  assign ich.priv = if_priv;
  assign dch.desc0 = desc_reg[ABAC_SEL_DATA0];
  assign dch.desc1 = desc_reg[ABAC_SEL_DATA1];
  assign dch.addr_hi = op_addr[ABAC_BASE_HI:ABAC_BASE_LO];
  assign dch.priv = op_priv;

  abac_access_checker u_instr (.c(ich));
  abac_access_checker u_data (.c(dch));

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      desc_next[i] = desc_reg[i];
    end
    rdata_next = rdata_reg;
    ack_next = 1'b0;
    perr_next = 1'b0;
    if ((ctl_wr || ctl_rd) && !ctl_super) begin
      perr_next = 1'b1;
    end else if (ctl_wr) begin
      desc_next[ctl_sel] = ctl_wdata & ABAC_WR_MASK;
      ack_next = 1'b1;
    end else if (ctl_rd) begin
      rdata_next = desc_reg[ctl_sel];
      ack_next = 1'b1;
    end
  end

  // fetch side: registered answer one cycle after the request
  always_comb begin
    if_valid_next = if_req;
    if_paddr_next = if_req ? if_addr : if_paddr_reg;
    if_pol_next = if_req ? ich.policy : if_pol_reg;
    if_ua_next = if_req ? ich.uattr : if_ua_reg;
  end

  // operand side: the write-protect abort rides with the answer
  always_comb begin
    op_valid_next = op_req;
    op_paddr_next = op_req ? op_addr : op_paddr_reg;
    op_pol_next = op_req ? dch.policy : op_pol_reg;
    op_ua_next = op_req ? dch.uattr : op_ua_reg;
    err_next = op_req && dch.wprot && (op_write || op_rmw);
  end

  // pins take the attributes latched by the last request of the chosen side
  always_comb begin
    pin_next = pin_reg;
    if (bus_start) begin
      pin_next = bus_is_data ? op_ua_reg : if_ua_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        desc_reg[i] <= ABAC_RESET_VAL;
      end
      rdata_reg <= 32'h00000000;
      ack_reg <= 1'b0;
      perr_reg <= 1'b0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        desc_reg[i] <= desc_next[i];
      end
      rdata_reg <= rdata_next;
      ack_reg <= ack_next;
      perr_reg <= perr_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      if_valid_reg <= 1'b0;
      if_paddr_reg <= 32'h00000000;
      if_pol_reg <= 2'h0;
      if_ua_reg <= 2'h0;
    end else begin
      if_valid_reg <= if_valid_next;
      if_paddr_reg <= if_paddr_next;
      if_pol_reg <= if_pol_next;
      if_ua_reg <= if_ua_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      op_valid_reg <= 1'b0;
      op_paddr_reg <= 32'h00000000;
      op_pol_reg <= 2'h0;
      op_ua_reg <= 2'h0;
      err_reg <= 1'b0;
    end else begin
      op_valid_reg <= op_valid_next;
      op_paddr_reg <= op_paddr_next;
      op_pol_reg <= op_pol_next;
      op_ua_reg <= op_ua_next;
      err_reg <= err_next;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_reg <= 2'h0;
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign ctl_rdata = rdata_reg;
  assign ctl_ack = ack_reg;
  assign ctl_priv_err = perr_reg;
  assign if_valid = if_valid_reg;
  assign if_paddr = if_paddr_reg;
  assign if_policy = if_pol_reg;
  assign if_uattr = if_ua_reg;
  assign if_page = if_paddr_reg[ABAC_DW-1:ABAC_PAGE_BITS];
  assign op_valid = op_valid_reg;
  assign op_paddr = op_paddr_reg;
  assign op_policy = op_pol_reg;
  assign op_uattr = op_ua_reg;
  assign op_page = op_paddr_reg[ABAC_DW-1:ABAC_PAGE_BITS];
  assign op_access_err = err_reg;
  assign user_attr_pin_hi = pin_reg[1];
  assign user_attr_pin_lo = pin_reg[0];
endmodule

// ==== abac_monitor.sv ====
// checker for abac_top: answer timing, pass-through and refusals at the ports
// assumes one mclk domain, rst_b active low
module abac_monitor (
  input logic mclk,
  input logic rst_b,
  input logic ctl_wr,
  input logic ctl_rd,
  input logic ctl_super,
  input logic ctl_ack,
  input logic ctl_priv_err,
  input logic if_req,
  input logic if_valid,
  input logic op_req,
  input logic op_valid,
  input logic op_write,
  input logic op_rmw,
  input logic op_access_err,
  input logic [31:0] if_addr,
  input logic [31:0] if_paddr,
  input logic [31:0] op_addr,
  input logic [31:0] op_paddr,
  input logic [19:0] if_page,
  input logic [19:0] op_page,
  input logic [1:0] if_uattr,
  input logic [1:0] op_uattr,
  input logic bus_start,
  input logic bus_is_data,
  input logic user_attr_pin_hi,
  input logic user_attr_pin_lo
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence s_req;
    ctl_wr || ctl_rd;
  endsequence
  AST_CTL_GOOD: assert property (s_req ##0 ctl_super |=> ctl_ack && !ctl_priv_err)
    else $error("no ack");
  AST_CTL_REFUSE: assert property (s_req ##0 !ctl_super |=> ctl_priv_err && !ctl_ack)
    else $error("no refusal");
  AST_CTL_IDLE: assert property (!ctl_wr && !ctl_rd |=> !ctl_ack && !ctl_priv_err)
    else $error("stray answer");
  AST_IF_PASS: assert property (if_req |=> if_valid && if_paddr == $past(if_addr))
    else $error("fetch answer");
  AST_OP_PASS: assert property (op_req |=> op_valid && op_paddr == $past(op_addr))
    else $error("operand answer");
  AST_IF_PULSE: assert property (!if_req |=> !if_valid)
    else $error("stray fetch valid");
  AST_PAGE: assert property (if_valid |-> if_page == if_paddr[31:12])
    else $error("page");
  AST_READ_OK: assert property (op_req && !op_write && !op_rmw |=> !op_access_err)
    else $error("read aborted");
  AST_ERR_VALID: assert property (op_access_err |-> op_valid)
    else $error("error without valid");
  sequence s_bus_op;
    bus_start && bus_is_data;
  endsequence
  sequence s_bus_if;
    bus_start && !bus_is_data;
  endsequence
  AST_OP_PULSE: assert property (!op_req |=> !op_valid)
    else $error("stray operand valid");
  AST_OP_PAGE: assert property (op_valid |-> op_page == op_paddr[31:12])
    else $error("operand page");
  AST_PIN_OP: assert property (s_bus_op |=> {user_attr_pin_hi, user_attr_pin_lo} == $past(op_uattr))
    else $error("operand pins");
  AST_PIN_IF: assert property (s_bus_if |=> {user_attr_pin_hi, user_attr_pin_lo} == $past(if_uattr))
    else $error("fetch pins");
  AST_PIN_HOLD: assert property (!bus_start |=> $stable(user_attr_pin_hi) && $stable(user_attr_pin_lo))
    else $error("pins moved");
  AST_ERR_WRITE: assert property (op_access_err |-> $past(op_write) || $past(op_rmw))
    else $error("abort on read");
endmodule
bind abac_top abac_monitor mon (.mclk, .rst_b, .ctl_wr, .ctl_rd, .ctl_super, .ctl_ack, .ctl_priv_err,
  .if_req, .if_valid, .op_req, .op_valid, .op_write, .op_rmw, .op_access_err,
  .if_addr, .if_paddr, .op_addr, .op_paddr, .if_page, .op_page, .if_uattr, .op_uattr,
  .bus_start, .bus_is_data, .user_attr_pin_hi, .user_attr_pin_lo);

// ==== abac_bus_model.sv ====
// bus controller stand-in: turns a request into a one-cycle bus_start
// assumes go changes off the rising edge
module abac_bus_model (
  input logic mclk,
  input logic go,
  input logic data_side,
  output logic bus_start = 1'b0,
  output logic bus_is_data = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // only plain transfers start, never page test or flush cycles
  always @(posedge mclk) begin
    bus_start <= go;
    bus_is_data <= go ? data_side : !bus_is_data;
  end
endmodule

// ==== test_address_block_access_control.sv ====
// testbench for abac_top: random descriptors, fetches, operands, bus cycles vs a bench model
// assumes abac_monitor bound in and abac_bus_model as bus controller
module test_address_block_access_control;
  import abac_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rst_b = 0, ctl_wr = 0, ctl_rd = 0, ctl_super = 0, go = 0, side = 0;
  logic if_req = 0, if_priv = 0, op_req = 0, op_priv = 0, op_write = 0, op_rmw = 0;
  logic [1:0] ctl_sel = 0, if_policy, if_uattr, op_policy, op_uattr;
  logic [31:0] ctl_wdata = 0, if_addr = 0, op_addr = 0, ctl_rdata, if_paddr, op_paddr, rv, lr = 0;
  logic ctl_ack, ctl_priv_err, if_valid, op_valid, op_access_err, bus_start, bus_is_data;
  logic user_attr_pin_hi, user_attr_pin_lo;
  logic [19:0] if_page, op_page;
  logic [31:0] d [4];
  logic [4:0] ei, eo;
  int fails = 0, n_compared = 0;
  always #2 mclk = ~mclk;
  abac_top uut (.mclk, .rst_b, .ctl_wr, .ctl_rd, .ctl_super, .ctl_sel, .ctl_wdata, .ctl_rdata, .ctl_ack,
    .ctl_priv_err, .if_req, .if_addr, .if_priv, .if_valid, .if_paddr, .if_policy, .if_uattr, .if_page,
    .op_req, .op_addr, .op_priv, .op_write, .op_rmw, .op_valid, .op_paddr, .op_policy, .op_uattr,
    .op_page, .op_access_err, .bus_start, .bus_is_data, .user_attr_pin_hi, .user_attr_pin_lo);
  abac_bus_model bm (.mclk, .go, .data_side(side), .bus_start, .bus_is_data);
  task chk(input logic [31:0] s, e, input string n);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function logic [4:0] exp_attr(int b, logic [31:0] a, logic p, logic w);
    logic [31:0] r;
    exp_attr = 5'h00;
    for (int i = 1; i >= 0; i--) begin
      r = d[b + i];
      if (r[15] && ((r[31:24] ^ a[31:24]) & ~r[23:16]) == 8'h00 && (r[14] || r[13] == p))
        exp_attr = {w & r[2], r[6:5], r[9:8]};
    end
  endfunction
  task ctl(input logic w, s, input logic [1:0] sel, input logic [31:0] v);
    @(negedge mclk);
    ctl_wr = w;
    ctl_rd = !w;
    ctl_super = s;
    ctl_sel = sel;
    ctl_wdata = v;
    @(negedge mclk);
    ctl_wr = 0;
    ctl_rd = 0;
    chk(ctl_ack, s, "ack");
    chk(ctl_priv_err, !s, "priv_err");
    if (s && w) d[sel] = v & ABAC_WR_MASK;
    if (s && !w) lr = d[sel];
    if (!w) chk(ctl_rdata, lr, "rdata");
  endtask
  initial begin
    #40000;
    fails++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h6DD1));
    d = '{default: 32'h0};
    repeat (16) @(negedge mclk);
    rst_b = 1;
    for (int k = 0; k < 300; k++) begin
      if (k == 150) begin
        rst_b = 0;
        @(negedge mclk);
        rst_b = 1;
        d = '{default: 32'h0};
        lr = 32'h0;
      end
      if (k % 50 == 0) for (int j = 0; j < 4; j++) ctl(0, 1, j[1:0], 0);
      rv = $urandom;
      ctl(1, rv[2:0] != 3'h0, rv[4:3], $urandom);
      ctl(0, rv[9:7] != 3'h0, rv[6:5], 0);
      @(negedge mclk);
      rv = $urandom;
      if_addr = $urandom;
      op_addr = $urandom;
      if (rv[0]) if_addr[31:24] = d[rv[1]][31:24] ^ (rv[15:8] & d[rv[1]][23:16]);
      if (rv[3]) op_addr[31:24] = d[{1'b1, rv[4]}][31:24] ^ (rv[23:16] & d[{1'b1, rv[4]}][23:16]);
      if_priv = rv[5];
      op_priv = rv[6];
      op_write = rv[7];
      op_rmw = rv[24] & !rv[7];
      if_req = 1;
      op_req = 1;
      ei = exp_attr(0, if_addr, if_priv, 0);
      eo = exp_attr(2, op_addr, op_priv, op_write | op_rmw);
      @(negedge mclk);
      if_req = 0;
      op_req = 0;
      chk(if_page, if_addr[31:12], "if_page");
      chk(op_page, op_addr[31:12], "op_page");
      chk({if_policy, if_uattr}, ei[3:0], "if_attr");
      chk({op_access_err, op_policy, op_uattr}, eo, "op_attr");
      side = rv[25];
      go = 1;
      @(negedge mclk);
      go = 0;
      @(negedge mclk);
      chk({user_attr_pin_hi, user_attr_pin_lo}, side ? eo[1:0] : ei[1:0], "pins");
    end
    print_verdict;
  end
endmodule
